// ===== src/evpm_pkg.sv
// constants for the exception vector and priority map
// assumes one clock domain and a core that fetches vectors by handshake
package evpm_pkg;

  // ****************************************************************
  // table layout
  // ****************************************************************
  localparam int          EVPM_NUM_POS     = 33;
  localparam int          EVPM_POS_W       = 6;
  localparam int          EVPM_PRIO_W      = 5;
  localparam int          EVPM_KEY_W       = 6;
  localparam int          EVPM_NUM_PERIPH  = 15;
  localparam int          EVPM_NUM_SYSTEM  = 10;
  localparam int          EVPM_NUM_IRQ     = 17;

  localparam logic [5:0]  POS_STACK_TOP    = 6'h00;
  localparam logic [5:0]  POS_RESET        = 6'h01;
  localparam logic [5:0]  POS_NMI          = 6'h02;
  localparam logic [5:0]  POS_HARD_FAULT   = 6'h03;
  localparam logic [5:0]  POS_MEM_FAULT    = 6'h04;
  localparam logic [5:0]  POS_BUS_FAULT    = 6'h05;
  localparam logic [5:0]  POS_USAGE_FAULT  = 6'h06;
  localparam logic [5:0]  POS_SVC          = 6'h0b;
  localparam logic [5:0]  POS_DEBUG_MON    = 6'h0c;
  localparam logic [5:0]  POS_PENDABLE_SERVICE_EXC       = 6'h0e;
  localparam logic [5:0]  POS_SYSTEM_TICK_EXC      = 6'h0f;
  localparam int          POS_PERIPH_BASE  = 18;

  // positions that may ever be raised; reserved ones stay zero
  localparam logic [32:0] RAISABLE_MASK    = 33'h1_d7bc_d87c;

  // ****************************************************************
  // priority keys: lower wins; fixed ones sit below every soft level
  // ****************************************************************
  localparam logic [5:0]  KEY_RESET        = 6'h00;
  localparam logic [5:0]  KEY_NMI          = 6'h01;
  localparam logic [5:0]  KEY_HARD_FAULT   = 6'h02;
  localparam logic [5:0]  KEY_SOFT_OFFSET  = 6'h03;
  localparam logic [5:0]  KEY_THREAD       = 6'h3f;

  // ****************************************************************
  // vector addressing
  // ****************************************************************
  localparam logic [31:0] VEC_BASE_RESET   = 32'h0000_0000;
  localparam int          VEC_ENTRY_SHIFT  = 2;

endpackage

// ===== src/evpm_arb_if.sv
// carrier between pending bank, arbiter and the top of the map
// assumes all parties run on the same clock
`timescale 1ns/1ps
interface evpm_arb_if;
  import evpm_pkg::*;
  logic [EVPM_NUM_POS-1:0]            raise;
  logic [EVPM_NUM_POS-1:0]            clr;
  logic [EVPM_NUM_POS-1:0]            pend;
  logic [EVPM_NUM_POS*EVPM_KEY_W-1:0] keys;
  logic                               win_valid;
  logic [EVPM_POS_W-1:0]              win_pos;
  logic [EVPM_KEY_W-1:0]              win_key;

  modport bank (input raise, input clr, output pend);
  modport arb  (input pend, output keys, output win_valid, output win_pos, output win_key);
  modport ctrl (output raise, output clr, input pend, input keys,
                input win_valid, input win_pos, input win_key);
endinterface

// ===== src/evpm_pend_bank.sv
// pending latches, one per table position
// assumes raise and clear come from the top of the map on the same clock
`timescale 1ns/1ps
module evpm_pend_bank
  import evpm_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  evpm_arb_if.bank  arb
);

  // ****************************************************************
  // latches: a raise in the clearing cycle keeps the bit set
  // ****************************************************************
  logic [EVPM_NUM_POS-1:0] pend_r;
  logic [EVPM_NUM_POS-1:0] pend_nxt;

  genvar g;
  generate
    for (g = 0; g < EVPM_NUM_POS; g++) begin : g_pend
      assign pend_nxt[g] = RAISABLE_MASK[g] & (arb.raise[g] | (pend_r[g] & ~arb.clr[g])); // R21
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign arb.pend = pend_r;

endmodule

// ===== src/evpm_prio_arbiter.sv
// picks the pending exception with the lowest priority key
// assumes soft priorities are held stable by the surrounding logic
`timescale 1ns/1ps
module evpm_prio_arbiter
  import evpm_pkg::*;
(
  input  wire logic [EVPM_NUM_POS*EVPM_PRIO_W-1:0] prio_cfg,
  evpm_arb_if.arb                                  arb
);

  // ****************************************************************
  // per-position key
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < EVPM_NUM_POS; g++) begin : g_key
      logic [EVPM_KEY_W-1:0] soft_key;
      assign soft_key = {1'b0, prio_cfg[g*EVPM_PRIO_W +: EVPM_PRIO_W]} + KEY_SOFT_OFFSET; // R20
      assign arb.keys[g*EVPM_KEY_W +: EVPM_KEY_W] =
        (g == 1) ? KEY_RESET :
        (g == 2) ? KEY_NMI :
        (g == 3) ? KEY_HARD_FAULT : soft_key;                                          // R04
    end
  endgenerate

  // ****************************************************************
  // selection: scanning downward, equal keys go to the lower position
  // ****************************************************************
  always_comb begin
    logic [EVPM_KEY_W-1:0] k;
    arb.win_valid = 1'b0;
    arb.win_pos   = '0;
    arb.win_key   = KEY_THREAD;
    k             = '0;
    for (int i = EVPM_NUM_POS - 1; i >= 0; i--) begin
      k = arb.keys[i*EVPM_KEY_W +: EVPM_KEY_W];
      if (arb.pend[i] && (!arb.win_valid || k <= arb.win_key)) begin                // R19
        arb.win_valid = 1'b1;
        arb.win_pos   = EVPM_POS_W'(i);
        arb.win_key   = k;
      end
    end
  end

endmodule

// ===== src/evpm_exception_map.sv
// exception vector and priority map: pends exceptions, picks one, fetches its vector
// assumes the core acknowledges each vector fetch and reports exception return
//
// Operation
// [R01] ten system exceptions plus seventeen peripheral inputs; the code has fifteen, at positions 18-32
// [R02] reset first fetches stack pointer from position zero
// [R03] each position holds a 32-bit handler address
// [R04] position sets vector location and hardware priority
// [R05] reset at position one, highest priority
// [R06] first reset instruction drops to thread level
// [R07] nmi at two, preempted only by reset
// [R08] hard fault when fault handler cannot activate
// [R09] memory fault on protection unit mismatch
// [R10] bus fault: precise synchronous, imprecise asynchronous
// [R11] usage fault on execution errors
// [R12] supervisor call on service-call instruction
// [R13] debug monitor only when enabled, not halting
// [R14] pendable service pended by software only
// [R15] system tick pends on timer expiry
// [R16] reserved positions; peripherals from eighteen upward
// [R17] mac timer, transmit, receive at 24-26
// [R18] requests a, c, d at 28-31; debug 32
// [R19] equal priority: lower position taken first
// [R20] other exceptions carry 5-bit software priority
// [R21] vector at base plus four times position
`timescale 1ns/1ps
module evpm_exception_map
  import evpm_pkg::*;
#(
  parameter logic [31:0] VEC_BASE = VEC_BASE_RESET
)(
  input  wire logic                                clk,
  input  wire logic                                sys_rst,
  input  wire logic                                nmi_req,
  input  wire logic                                mem_fault_req,
  input  wire logic                                bus_fault_precise,
  input  wire logic                                bus_fault_imprecise,
  input  wire logic                                usage_fault_req,
  input  wire logic                                mem_fault_en,
  input  wire logic                                bus_fault_en,
  input  wire logic                                usage_fault_en,
  input  wire logic                                svc_exec,
  input  wire logic                                debug_mon_req,
  input  wire logic                                debug_mon_en,
  input  wire logic                                debug_halting,
  input  wire logic                                pendable_service_exc_sw_set,
  input  wire logic                                system_tick_exc_expire,
  input  wire logic [EVPM_NUM_PERIPH-1:0]          periph_irq,
  input  wire logic [EVPM_NUM_POS*EVPM_PRIO_W-1:0] prio_cfg,
  input  wire logic                                vec_ack,
  input  wire logic                                first_instr,
  input  wire logic                                exc_return,
  input  wire logic [EVPM_KEY_W-1:0]               ret_level,
  output logic                                     vec_fetch_r,
  output logic [31:0]                              vec_addr_r,
  output logic [EVPM_POS_W-1:0]                    exc_num_r,
  output logic [EVPM_KEY_W-1:0]                    exec_level_r
);

  // ****************************************************************
  // sub-blocks
  // ****************************************************************
  evpm_arb_if arb_if ();

  evpm_pend_bank u_bank (
    .clk     (clk),
    .sys_rst (sys_rst),
    .arb     (arb_if.bank)
  );

  evpm_prio_arbiter u_arb (
    .prio_cfg (prio_cfg),
    .arb      (arb_if.arb)
  );

  typedef enum logic [1:0] {
    ST_FETCH_SP,
    ST_FETCH_RST,
    ST_RESET_RUN,
    ST_RUN
  } evpm_state_t;

  evpm_state_t               state_r;
  evpm_state_t               state_nxt;
  logic [EVPM_KEY_W-1:0]     taken_key_r;

  // ****************************************************************
  // keys of the synchronous faults and the debug monitor, for the activation check
  // ****************************************************************
  wire logic [EVPM_KEY_W-1:0] key_mem   = arb_if.keys[POS_MEM_FAULT*EVPM_KEY_W +: EVPM_KEY_W];
  wire logic [EVPM_KEY_W-1:0] key_bus   = arb_if.keys[POS_BUS_FAULT*EVPM_KEY_W +: EVPM_KEY_W];
  wire logic [EVPM_KEY_W-1:0] key_usage = arb_if.keys[POS_USAGE_FAULT*EVPM_KEY_W +: EVPM_KEY_W];
  wire logic [EVPM_KEY_W-1:0] key_dbg   = arb_if.keys[POS_DEBUG_MON*EVPM_KEY_W +: EVPM_KEY_W];

  wire logic mem_ok   = mem_fault_en && (key_mem < exec_level_r);
  wire logic bus_ok   = bus_fault_en && (key_bus < exec_level_r);
  wire logic usage_ok = usage_fault_en && (key_usage < exec_level_r);

  wire logic mem_raise   = mem_fault_req && mem_ok;                                 // R09
  wire logic bus_raise   = (bus_fault_precise && bus_ok) || bus_fault_imprecise;    // R10
  wire logic usage_raise = usage_fault_req && usage_ok;                             // R11
  wire logic hard_raise  = (mem_fault_req && !mem_ok) ||
                           (bus_fault_precise && !bus_ok) ||
                           (usage_fault_req && !usage_ok);                          // R08
  wire logic dbg_raise   = debug_mon_req && debug_mon_en && !debug_halting &&
                           (key_dbg < exec_level_r);                                // R13

  // ****************************************************************
  // raise vector
  // ****************************************************************
  logic [EVPM_NUM_POS-1:0] sys_raise;
  logic [EVPM_NUM_POS-1:0] periph_raise;

  always_comb begin
    sys_raise                  = '0;
    sys_raise[POS_NMI]         = nmi_req;                                           // R07
    sys_raise[POS_HARD_FAULT]  = hard_raise;
    sys_raise[POS_MEM_FAULT]   = mem_raise;
    sys_raise[POS_BUS_FAULT]   = bus_raise;
    sys_raise[POS_USAGE_FAULT] = usage_raise;
    sys_raise[POS_SVC]         = svc_exec;                                          // R12
    sys_raise[POS_DEBUG_MON]   = dbg_raise;
    sys_raise[POS_PENDABLE_SERVICE_EXC]      = pendable_service_exc_sw_set;                                     // R14
    sys_raise[POS_SYSTEM_TICK_EXC]     = system_tick_exc_expire;                                    // R15
  end

  // peripheral line i lands at position 18+i; reserved slots are masked off
  assign periph_raise = {periph_irq, {POS_PERIPH_BASE{1'b0}}};                     // R16 R17 R18
  assign arb_if.raise = (sys_raise | periph_raise) & RAISABLE_MASK;                // R01 R21

  // ****************************************************************
  // vector fetch control
  // ****************************************************************
  wire logic take_now = (state_r == ST_RUN) && !vec_fetch_r && arb_if.win_valid &&
                        (arb_if.win_key < exec_level_r);                            // R07 R19
  wire logic ack_exc  = vec_fetch_r && vec_ack && (state_r == ST_RUN);
  wire logic [31:0] win_addr = VEC_BASE +
                               {24'h000000, arb_if.win_pos, 2'b00};                 // R21
  wire logic [31:0] rst_addr = VEC_BASE +
                               {24'h000000, POS_RESET, 2'b00};                      // R05

  always_comb begin
    arb_if.clr = '0;
    if (ack_exc) begin
      arb_if.clr[exc_num_r] = 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_FETCH_SP: begin
        if (vec_ack) begin
          state_nxt = ST_FETCH_RST;
        end
      end
      ST_FETCH_RST: begin
        if (vec_ack) begin
          state_nxt = ST_RESET_RUN;
        end
      end
      ST_RESET_RUN: begin
        if (first_instr) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_FETCH_SP;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_FETCH_SP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // stack pointer is fetched from position zero before any code runs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vec_fetch_r <= 1'b1;                                                          // R02
      vec_addr_r  <= VEC_BASE;
      exc_num_r   <= POS_STACK_TOP;
    end else if (state_r == ST_FETCH_SP && vec_ack) begin
      vec_fetch_r <= 1'b1;                                                          // R05
      vec_addr_r  <= rst_addr;
      exc_num_r   <= POS_RESET;
    end else if (take_now) begin
      vec_fetch_r <= 1'b1;                                                          // R03
      vec_addr_r  <= win_addr;
      exc_num_r   <= arb_if.win_pos;
    end else if (vec_ack) begin
      vec_fetch_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      taken_key_r <= KEY_THREAD;
    end else if (take_now) begin
      taken_key_r <= arb_if.win_key;
    end
  end

  // ****************************************************************
  // execution level
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      exec_level_r <= KEY_RESET;                                                    // R05
    end else if (state_r == ST_RESET_RUN && first_instr) begin
      exec_level_r <= KEY_THREAD;                                                   // R06
    end else if (ack_exc) begin
      exec_level_r <= taken_key_r;                                                  // R04
    end else if (exc_return && state_r == ST_RUN) begin
      exec_level_r <= ret_level;
    end
  end

endmodule

// ===== verification/evpm_exception_map_asserts.sv
// port assertions for the exception vector and priority map
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module evpm_exception_map_asserts
  import evpm_pkg::*;
#(
  parameter logic [31:0] VEC_BASE = VEC_BASE_RESET
)(
  input wire logic         clk,
  input wire logic         sys_rst,
  input wire logic [164:0] prio_cfg,
  input wire logic         vec_ack,
  input wire logic         first_instr,
  input wire logic         exc_return,
  input wire logic         vec_fetch_r,
  input wire logic [31:0]  vec_addr_r,
  input wire logic [5:0]   exc_num_r,
  input wire logic [5:0]   exec_level_r
);
  logic [5:0] exp_key;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // key of the position being fetched
  assign exp_key = (exc_num_r == POS_NMI) ? KEY_NMI :
                   (exc_num_r == POS_HARD_FAULT) ? KEY_HARD_FAULT :
                   {1'b0, prio_cfg[exc_num_r*5 +: 5]} + KEY_SOFT_OFFSET;

  // ****************************************
  // fetch and level checks
  // ****************************************
  reset_state_a: assert property (
    $fell(sys_rst) |-> vec_fetch_r && exc_num_r == POS_STACK_TOP && vec_addr_r == VEC_BASE
      && exec_level_r == KEY_RESET) else $error("bad state after reset");
  boot_order_a: assert property (
    vec_fetch_r && vec_ack && exc_num_r == POS_STACK_TOP |=> vec_fetch_r
      && exc_num_r == POS_RESET && exec_level_r == KEY_RESET) else $error("no reset vector");
  fetch_hold_a: assert property (
    vec_fetch_r && !vec_ack |=> vec_fetch_r && $stable(vec_addr_r) && $stable(exc_num_r))
    else $error("fetch moved before ack");
  vec_addr_a: assert property (
    vec_fetch_r |-> vec_addr_r == VEC_BASE + {24'h0, exc_num_r, 2'b00})
    else $error("vector address wrong");
  reserved_pos_a: assert property (
    vec_fetch_r |-> exc_num_r <= POS_RESET || (exc_num_r <= 6'h20 && RAISABLE_MASK[exc_num_r]))
    else $error("reserved position fetched");
  thread_drop_a: assert property (
    first_instr && !vec_fetch_r && exec_level_r == KEY_RESET |=> exec_level_r == KEY_THREAD)
    else $error("no drop to thread");
  take_level_a: assert property (
    vec_fetch_r && vec_ack && exc_num_r > POS_RESET |=> exec_level_r == $past(exp_key))
    else $error("wrong level after take");
  win_level_a: assert property (
    $rose(vec_fetch_r) && exc_num_r > POS_RESET |-> exp_key < exec_level_r)
    else $error("take without priority");
  nmi_hold_a: assert property (
    exec_level_r == KEY_NMI && !vec_fetch_r && !exc_return |=> !vec_fetch_r)
    else $error("nmi preempted");

  cover property (vec_fetch_r && vec_ack && exc_num_r == POS_RESET);
  cover property (vec_fetch_r && vec_ack && exc_num_r == POS_NMI);
  cover property (vec_fetch_r && vec_ack && exc_num_r == POS_HARD_FAULT);
endmodule

bind evpm_exception_map evpm_exception_map_asserts #(.VEC_BASE(VEC_BASE)) u_asserts (
  .clk, .sys_rst, .prio_cfg, .vec_ack, .first_instr, .exc_return, .vec_fetch_r,
  .vec_addr_r, .exc_num_r, .exec_level_r
);

// ===== verification/evpm_core_model.sv
// core model: acknowledges vector fetches, reports the first reset instruction
// assumes the bench sets the answer delay and drives exception return
`timescale 1ns/1ps
module evpm_core_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       vec_fetch_r,
  input  wire logic [5:0] exc_num_r,
  input  wire logic [3:0] ack_delay,
  output logic            vec_ack,
  output logic            first_instr
);
  logic [3:0] wait_r = 4'h0;
  logic       boot_r = 1'b0;

  // answers change after the falling edge and stand across one rising edge
  initial vec_ack = 1'b0;
  initial first_instr = 1'b0;
  always @(negedge clk) begin
    vec_ack     <= 1'b0;
    first_instr <= 1'b0;
    if (sys_rst) begin
      wait_r <= 4'h0;
    end else if (vec_fetch_r && !vec_ack) begin
      wait_r <= wait_r + 4'h1;
      if (wait_r >= ack_delay) begin
        vec_ack <= 1'b1;
        wait_r  <= 4'h0;
        boot_r  <= (exc_num_r == 6'h01);
      end
    end else if (boot_r && !vec_fetch_r) begin
      first_instr <= 1'b1;
      boot_r      <= 1'b0;
    end
  end
endmodule

// ===== verification/tb_top.sv
// bench for the exception map: boot, system exceptions, nesting, peripheral order
// assumes the core model answers fetches; exception return is driven here
`timescale 1ns/1ps
module tb_top;
  import evpm_pkg::*;
  localparam logic [5:0] SRC_POS [9] = '{6'h02, 6'h04, 6'h05, 6'h05, 6'h06, 6'h0b, 6'h0c,
                                         6'h0e, 6'h0f};
  logic         clk;
  logic         sys_rst;
  logic [8:0]   src;
  logic [2:0]   fault_en;
  logic         mon_en;
  logic         halting;
  logic [14:0]  periph_irq;
  logic [164:0] prio_cfg;
  logic         exc_return;
  logic [5:0]   ret_level;
  logic [3:0]   ack_delay;
  logic         vec_ack;
  logic         first_instr;
  logic         vec_fetch_r;
  logic [31:0]  vec_addr_r;
  logic [5:0]   exc_num_r;
  logic [5:0]   exec_level_r;
  logic [5:0]   took_q[$];
  logic [31:0]  addr_q[$];
  logic [14:0]  v;
  logic [32:0]  m;
  logic [5:0]   w;
  int           n_mismatch;
  int           num_checks;
  int           seed;

  evpm_exception_map DUT (
    .clk, .sys_rst, .nmi_req(src[0]), .mem_fault_req(src[1]), .bus_fault_precise(src[2]),
    .bus_fault_imprecise(src[3]), .usage_fault_req(src[4]), .mem_fault_en(fault_en[0]),
    .bus_fault_en(fault_en[1]), .usage_fault_en(fault_en[2]), .svc_exec(src[5]),
    .debug_mon_req(src[6]), .debug_mon_en(mon_en), .debug_halting(halting),
    .pendable_service_exc_sw_set(src[7]), .system_tick_exc_expire(src[8]), .periph_irq, .prio_cfg, .vec_ack,
    .first_instr, .exc_return, .ret_level, .vec_fetch_r, .vec_addr_r, .exc_num_r,
    .exec_level_r
  );
  evpm_core_model core (
    .clk, .sys_rst, .vec_fetch_r, .exc_num_r, .ack_delay, .vec_ack, .first_instr
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (vec_fetch_r === 1'b1 && vec_ack === 1'b1) begin
      took_q.push_back(exc_num_r);
      addr_q.push_back(vec_addr_r);
    end
  end

  // ****************************************
  // expectations and drivers
  // ****************************************
  function automatic logic [5:0] key_of(input logic [5:0] pos);
    if (pos <= 6'h01) return 6'h00;
    if (pos == 6'h02) return 6'h01;
    if (pos == 6'h03) return 6'h02;
    return {1'b0, prio_cfg[pos*5 +: 5]} + 6'h03;
  endfunction
  // lowest key wins, ties go to the lower position
  function automatic logic [5:0] winner(input logic [32:0] mask);
    logic [5:0] best = 6'h3f;
    for (int p = 32; p >= 0; p--) begin
      if (mask[p] && (best == 6'h3f || key_of(6'(p)) <= key_of(best))) best = 6'(p);
    end
    return best;
  endfunction
  task automatic cmp_val(input logic [5:0] exp, input logic [5:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic cmp_addr(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  // 6'h3f means no fetch may be taken
  task automatic take(input logic [5:0] exp);
    logic [5:0]  got = 6'h3f;
    logic [31:0] adr = 32'h0;
    repeat (40) begin
      if (took_q.size() == 0) @(negedge clk);
    end
    if (took_q.size() != 0) begin
      got = took_q.pop_front();
      adr = addr_q.pop_front();
    end
    cmp_val(exp, got);
    if (exp != 6'h3f) cmp_val(key_of(exp), exec_level_r);
    if (exp != 6'h3f) cmp_addr(VEC_BASE_RESET + {24'h0, exp, 2'b00}, adr);
  endtask
  task automatic ret_to(input logic [5:0] lvl);
    @(negedge clk);
    ret_level  <= lvl;
    exc_return <= 1'b1;
    @(negedge clk);
    exc_return <= 1'b0;
  endtask
  task automatic fire(input int i);
    src[i] <= 1'b1;
    @(negedge clk);
    src[i] <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #600000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    seed = 32'h3acc4905;
    sys_rst = 1'b1;
    src = 9'h000;
    fault_en = 3'h7;
    mon_en = 1'b1;
    halting = 1'b0;
    periph_irq = 15'h0000;
    prio_cfg = '0;
    exc_return = 1'b0;
    ret_level = 6'h3f;
    ack_delay = 4'h0;
    repeat (2) @(negedge clk);
    sys_rst <= 1'b0;
    take(6'h00);
    take(6'h01);
    repeat (6) @(negedge clk);
    cmp_val(6'h3f, exec_level_r);
    for (int i = 0; i < 9; i++) begin
      prio_cfg <= 165'({6{$random(seed)}});
      ack_delay <= 4'($random(seed)) & 4'h3;
      fire(i);
      take(SRC_POS[i]);
      ret_to(6'h3f);
    end
    fire(8);
    take(6'h0f);
    fire(0);
    take(6'h02);
    fire(1);
    fire(6);
    take(6'h3f);
    ret_to(6'h3f);
    take(6'h03);
    ret_to(6'h3f);
    fault_en <= 3'h0;
    fire(4);
    take(6'h03);
    ret_to(6'h3f);
    fire(3);
    take(6'h05);
    ret_to(6'h3f);
    mon_en <= 1'b0;
    fire(6);
    take(6'h3f);
    mon_en <= 1'b1;
    halting <= 1'b1;
    fire(6);
    take(6'h3f);
    halting <= 1'b0;
    for (int n = 0; n < 20; n++) begin
      v = (n == 0) ? 15'h1400 : 15'($random(seed));
      prio_cfg <= (n == 0) ? '0 : 165'({6{$random(seed)}}) & {33{5'h03}};
      periph_irq <= v;
      @(negedge clk);
      periph_irq <= 15'h0000;
      m = {v, 18'h00000} & RAISABLE_MASK;
      if (m == 33'h0) take(6'h3f);
      while (m != 33'h0) begin
        w = winner(m);
        take(w);
        ret_to(6'h3f);
        m[w] = 1'b0;
      end
    end
    // warm reset: a raise inside reset must not survive it
    sys_rst <= 1'b1;
    fire(8);
    @(negedge clk);
    sys_rst <= 1'b0;
    take(6'h00);
    take(6'h01);
    repeat (6) @(negedge clk);
    cmp_val(6'h3f, exec_level_r);
    take(6'h3f);
    finish_test();
  end
endmodule
